// ### cc_detect_params.svh
`ifndef CC_DETECT_PARAMS_SVH
`define CC_DETECT_PARAMS_SVH

// register offsets
`define OFS_CONTROL     4'h0
`define OFS_SWITCHES    4'h1
`define OFS_MEASURE     4'h2
`define OFS_SRC_CURRENT 4'h3
`define OFS_STATUS      4'h4
`define OFS_IRQ_STATUS  4'h5
`define OFS_IRQ_MASK    4'h6

// control register fields
`define CTL_TOGGLE_BIT  0
`define CTL_MODE_LSB    1
`define CTL_MODE_MSB    2

// switches register fields
`define SW_CC1_PULLDOWN_ENABLE_BIT    0
`define SW_CC2_PULLDOWN_ENABLE_BIT    1
`define SW_PU1_BIT      2
`define SW_PU2_BIT      3
`define SW_MEAS1_BIT    4
`define SW_MEAS2_BIT    5
`define SW_CABLE1_BIT   6
`define SW_CABLE2_BIT   7

// measure register fields
`define MEAS_DAC_MSB    5
`define MEASURE_VBUS_SELECT_BIT   6

// status register fields
`define ST_LEVEL_MSB    1
`define ST_COMP_BIT     2
`define ST_VBUS_BIT     3
`define ST_TOG_LSB      4
`define ST_TOG_MSB      6

// interrupt bits
`define IRQ_LEVEL_BIT   0
`define IRQ_COMP_BIT    1
`define IRQ_VBUS_BIT    2
`define IRQ_TOGDONE_BIT 3

// reset values
`define RST_CONTROL     8'h00
`define RST_SWITCHES    8'h03
`define RST_MEASURE     8'h00
`define RST_SRC_CURRENT 2'h1
`define RST_IRQ_MASK    4'h0

// toggle result codes
`define TOG_NONE        3'h0
`define TOG_SRC_CC1     3'h1
`define TOG_SRC_CC2     3'h2
`define TOG_SNK_CC1     3'h5
`define TOG_SNK_CC2     3'h6

// pin presentations {meas2, meas1, pu2, pu1, cc2_pulldown_enable, cc1_pulldown_enable}
`define PINS_RST        6'h03
`define PINS_SRC_CC1    6'h1c
`define PINS_SRC_CC2    6'h2c
`define PINS_SNK_CC1    6'h13
`define PINS_SNK_CC2    6'h23
`define PINS_OFF        6'h00

// sink level code of the ra range
`define LEVEL_RA        2'h0

// toggle dwell per pin, in microseconds
`define CLK_MHZ         50
`define TOGGLE_DWELL_US 40
`define TOGGLE_DWELL_CYC (`TOGGLE_DWELL_US * `CLK_MHZ)

`endif

// ### cc_detect_pkg.sv
package cc_detect_pkg;

   typedef enum logic [1:0] {
      MODE_DUAL_ROLE,
      MODE_SOURCE_ONLY,
      MODE_SINK_ONLY,
      MODE_SPARE
   } toggle_mode_e;

   typedef enum logic [2:0] {
      TG_IDLE,
      TG_SRC_CC1,
      TG_SRC_CC2,
      TG_SNK_CC1,
      TG_SNK_CC2,
      TG_DONE
   } toggle_state_e;

   typedef logic [7:0] reg_data_t;

endpackage : cc_detect_pkg

// ### typec_cc_attach_detection.sv
// Functional notes
// - a fixed CC level change raises both level and compare interrupts; a compare change raises compare only
// - six-bit DAC threshold; compare output readable by software
// - VBUS valid comparator; DAC may be steered onto VBUS
// - toggling drives pull-downs, pull-ups and measure selects, source then sink
// - source-only or sink-only toggling polls both CC pins repeatedly
// - on resolution raise toggle-done and report role and orientation
// - toggle off: pin controls follow software-written values
// - VBUS valid flag and interrupt track host attach and detach
// - sink level code 00 Ra, 01 default, 10 1.5A, 11 3.0A
// - current selected before attach is advertised on attach
// - current changed while attached switches the pull-up at once
// - Ra as source reads per current setting via level code and compare
// - pending unmasked interrupts drive an active-low open-drain output
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "cc_detect_params.svh"

module typec_cc_attach_detection
   import cc_detect_pkg::*;
(
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   // register port
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // analog comparator results
   input  wire logic [1:0] cc_level_code_raw,
   input  wire logic       dac_compare_raw,
   input  wire logic       vbus_valid_raw,
   // analog controls
   output logic            cc1_pulldown_enable,
   output logic            cc2_pulldown_enable,
   output logic            cc1_pullup_enable,
   output logic            cc2_pullup_enable,
   output logic            measure_cc1_select,
   output logic            measure_cc2_select,
   output logic            measure_vbus_select,
   output logic      [5:0] dac_threshold_code,
   output logic      [1:0] source_current_select,
   output logic            cable_power_to_cc1,
   output logic            cable_power_to_cc2,
   // interrupt pin, open drain
   output logic            int_n_out,
   output logic            int_n_oe
);

   localparam logic [11:0] DWELL_LAST = 12'(`TOGGLE_DWELL_CYC - 1);

   // register state
   reg_data_t     control_reg;
   reg_data_t     switches_reg;
   reg_data_t     measure_reg;
   logic [1:0]    src_current_reg;
   logic [3:0]    irq_reg;
   logic [3:0]    irq_next;
   logic [3:0]    mask_reg;
   reg_data_t     rdata_reg;
   reg_data_t     rdata_next;

   // synchronisers
   logic [1:0]    level_meta_reg;
   logic [1:0]    level_reg;
   logic [1:0]    level_old_reg;
   logic          comp_meta_reg;
   logic          comp_reg;
   logic          comp_old_reg;
   logic          vbus_meta_reg;
   logic          vbus_reg;
   logic          vbus_old_reg;

   // toggle engine
   toggle_state_e tg_state_reg;
   toggle_state_e tg_state_next;
   logic [11:0]   dwell_reg;
   logic [11:0]   dwell_next;
   logic [2:0]    tog_result_reg;
   logic [2:0]    tog_result_next;

   // pin control registers
   logic [5:0]    pins_reg;
   logic [5:0]    pins_next;
   logic          int_oe_reg;

   // address decode
   wire logic wr_control  = reg_wr && (reg_addr == `OFS_CONTROL);
   wire logic wr_switches = reg_wr && (reg_addr == `OFS_SWITCHES);
   wire logic wr_measure  = reg_wr && (reg_addr == `OFS_MEASURE);
   wire logic wr_current  = reg_wr && (reg_addr == `OFS_SRC_CURRENT);
   wire logic wr_irq      = reg_wr && (reg_addr == `OFS_IRQ_STATUS);
   wire logic wr_mask     = reg_wr && (reg_addr == `OFS_IRQ_MASK);
   wire logic rd_irq      = reg_rd && (reg_addr == `OFS_IRQ_STATUS);

   wire logic         toggle_en = control_reg[`CTL_TOGGLE_BIT];
   wire toggle_mode_e tg_mode   = toggle_mode_e'(control_reg[`CTL_MODE_MSB:`CTL_MODE_LSB]);
   wire logic         dwell_end = (dwell_reg == DWELL_LAST);

   // comparator change events
   wire logic level_chg = (level_reg != level_old_reg);
   wire logic comp_chg  = (comp_reg != comp_old_reg);
   wire logic vbus_chg  = (vbus_reg != vbus_old_reg);

   // sink sees a source when the level code leaves the ra range
   wire logic snk_seen  = (level_reg != `LEVEL_RA);
   // source sees rd when the compare falls under the programmed threshold
   wire logic src_seen  = !comp_reg;

   // fires once, on the cycle the engine enters its done state
   wire logic tg_done_rise = (tg_state_next == TG_DONE) && (tg_state_reg != TG_DONE);

   wire logic [3:0] irq_events = {
      tg_done_rise,
      vbus_chg,
      level_chg || comp_chg,
      level_chg
   };

   wire reg_data_t status_word = {
      1'b0,
      tog_result_reg,
      vbus_reg,
      comp_reg,
      level_reg
   };

   // toggle sequencing
   // a phase resolves only on its last cycle, long after the synced inputs settle
   always_comb begin
      tg_state_next   = tg_state_reg;
      dwell_next      = dwell_end ? 12'h000 : dwell_reg + 12'h001;
      tog_result_next = tog_result_reg;
      if (!toggle_en) begin
         tg_state_next   = TG_IDLE;
         dwell_next      = 12'h000;
         tog_result_next = `TOG_NONE;
      end else begin
         case (tg_state_reg)
            TG_IDLE: begin
               dwell_next    = 12'h000;
               tg_state_next = (tg_mode == MODE_SINK_ONLY) ? TG_SNK_CC1 : TG_SRC_CC1;
            end
            TG_SRC_CC1: begin
               if (dwell_end) begin
                  if (src_seen) begin
                     tg_state_next   = TG_DONE;
                     tog_result_next = `TOG_SRC_CC1;
                  end else begin
                     tg_state_next = TG_SRC_CC2;
                  end
               end
            end
            TG_SRC_CC2: begin
               if (dwell_end) begin
                  if (src_seen) begin
                     tg_state_next   = TG_DONE;
                     tog_result_next = `TOG_SRC_CC2;
                  end else if (tg_mode == MODE_SOURCE_ONLY) begin
                     tg_state_next = TG_SRC_CC1;
                  end else begin
                     tg_state_next = TG_SNK_CC1;
                  end
               end
            end
            TG_SNK_CC1: begin
               if (dwell_end) begin
                  if (snk_seen) begin
                     tg_state_next   = TG_DONE;
                     tog_result_next = `TOG_SNK_CC1;
                  end else begin
                     tg_state_next = TG_SNK_CC2;
                  end
               end
            end
            TG_SNK_CC2: begin
               if (dwell_end) begin
                  if (snk_seen) begin
                     tg_state_next   = TG_DONE;
                     tog_result_next = `TOG_SNK_CC2;
                  end else if (tg_mode == MODE_SINK_ONLY) begin
                     tg_state_next = TG_SNK_CC1;
                  end else begin
                     tg_state_next = TG_SRC_CC1;
                  end
               end
            end
            TG_DONE: begin
               // holds the resolved role until software drops the toggle enable
               dwell_next = 12'h000;
            end
            default: begin
               tg_state_next = TG_IDLE;
            end
         endcase
      end
   end

   // pin controls: {meas2, meas1, pu2, pu1, cc2_pulldown_enable, cc1_pulldown_enable}
   // a source presents both pull-ups and measures one pin at a time
   always_comb begin
      pins_next = switches_reg[`SW_MEAS2_BIT:`SW_CC1_PULLDOWN_ENABLE_BIT];
      if (toggle_en) begin
         case (tg_state_reg)
            TG_SRC_CC1: pins_next = `PINS_SRC_CC1;
            TG_SRC_CC2: pins_next = `PINS_SRC_CC2;
            TG_SNK_CC1: pins_next = `PINS_SNK_CC1;
            TG_SNK_CC2: pins_next = `PINS_SNK_CC2;
            TG_DONE: begin
               case (tog_result_reg)
                  `TOG_SRC_CC1: pins_next = `PINS_SRC_CC1;
                  `TOG_SRC_CC2: pins_next = `PINS_SRC_CC2;
                  `TOG_SNK_CC1: pins_next = `PINS_SNK_CC1;
                  default:      pins_next = `PINS_SNK_CC2;
               endcase
            end
            default: pins_next = `PINS_OFF;
         endcase
      end
   end

   // flags: set wins over either clear path
   // a read clears every flag, so software must act on the whole word
   always_comb begin
      irq_next = irq_reg;
      if (rd_irq) begin
         irq_next = 4'h0;
      end
      if (wr_irq) begin
         irq_next = irq_next & ~reg_wdata[3:0];
      end
      irq_next = irq_next | irq_events;
   end

   // read mux, unmapped offsets read zero
   always_comb begin
      case (reg_addr)
         `OFS_CONTROL:     rdata_next = control_reg;
         `OFS_SWITCHES:    rdata_next = switches_reg;
         `OFS_MEASURE:     rdata_next = measure_reg;
         `OFS_SRC_CURRENT: rdata_next = {6'h00, src_current_reg};
         `OFS_STATUS:      rdata_next = status_word;
         `OFS_IRQ_STATUS:  rdata_next = {4'h0, irq_reg};
         `OFS_IRQ_MASK:    rdata_next = {4'h0, mask_reg};
         default:          rdata_next = 8'h00;
      endcase
      // idle cycles read zero so stale data never stands
      if (!reg_rd) begin
         rdata_next = 8'h00;
      end
   end

   // comparators are asynchronous: two flops, then one more copy for edges
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         level_meta_reg <= 2'h0;
         level_reg      <= 2'h0;
         level_old_reg  <= 2'h0;
         comp_meta_reg  <= 1'b0;
         comp_reg       <= 1'b0;
         comp_old_reg   <= 1'b0;
         vbus_meta_reg  <= 1'b0;
         vbus_reg       <= 1'b0;
         vbus_old_reg   <= 1'b0;
      end else begin
         level_meta_reg <= cc_level_code_raw;
         level_reg      <= level_meta_reg;
         level_old_reg  <= level_reg;
         comp_meta_reg  <= dac_compare_raw;
         comp_reg       <= comp_meta_reg;
         comp_old_reg   <= comp_reg;
         vbus_meta_reg  <= vbus_valid_raw;
         vbus_reg       <= vbus_meta_reg;
         vbus_old_reg   <= vbus_reg;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         control_reg     <= `RST_CONTROL;
         switches_reg    <= `RST_SWITCHES;
         measure_reg     <= `RST_MEASURE;
         src_current_reg <= `RST_SRC_CURRENT;
         mask_reg        <= `RST_IRQ_MASK;
      end else begin
         if (wr_control)  control_reg     <= reg_wdata;
         if (wr_switches) switches_reg    <= reg_wdata;
         if (wr_measure)  measure_reg     <= {1'b0, reg_wdata[6:0]};
         if (wr_current)  src_current_reg <= reg_wdata[1:0];
         if (wr_mask)     mask_reg        <= reg_wdata[3:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         irq_reg        <= 4'h0;
         rdata_reg      <= 8'h00;
         tg_state_reg   <= TG_IDLE;
         dwell_reg      <= 12'h000;
         tog_result_reg <= `TOG_NONE;
         pins_reg       <= `PINS_RST;
         int_oe_reg     <= 1'b0;
      end else begin
         irq_reg        <= irq_next;
         rdata_reg      <= rdata_next;
         tg_state_reg   <= tg_state_next;
         dwell_reg      <= dwell_next;
         tog_result_reg <= tog_result_next;
         pins_reg       <= pins_next;
         int_oe_reg     <= |(irq_next & ~mask_reg);
      end
   end

   assign reg_rdata             = rdata_reg;
   assign cc1_pulldown_enable   = pins_reg[`SW_CC1_PULLDOWN_ENABLE_BIT];
   assign cc2_pulldown_enable   = pins_reg[`SW_CC2_PULLDOWN_ENABLE_BIT];
   assign cc1_pullup_enable     = pins_reg[`SW_PU1_BIT];
   assign cc2_pullup_enable     = pins_reg[`SW_PU2_BIT];
   assign measure_cc1_select    = pins_reg[`SW_MEAS1_BIT];
   assign measure_cc2_select    = pins_reg[`SW_MEAS2_BIT];
   // dac may be steered onto vbus instead of the selected cc pin
   assign measure_vbus_select   = measure_reg[`MEASURE_VBUS_SELECT_BIT];
   assign dac_threshold_code    = measure_reg[`MEAS_DAC_MSB:0];
   // pull-up strength follows the register at once, attached or not
   assign source_current_select = src_current_reg;
   assign cable_power_to_cc1    = switches_reg[`SW_CABLE1_BIT];
   assign cable_power_to_cc2    = switches_reg[`SW_CABLE2_BIT];
   // open drain: only ever pulls low
   assign int_n_out             = 1'b0;
   assign int_n_oe              = int_oe_reg;

endmodule : typec_cc_attach_detection
`default_nettype wire

// ### cc_far_port.sv
`timescale 1ns/1ns
`default_nettype none
module cc_far_port (
   // design pin controls
   input  wire logic       cc1_pullup_enable,
   input  wire logic       cc2_pullup_enable,
   input  wire logic       measure_cc1_select,
   input  wire logic       measure_vbus_select,
   input  wire logic [5:0] dac_threshold_code,
   input  wire logic [1:0] source_current_select,
   // far termination: 0 open, 1 rd, 2 ra, 3 source
   input  wire logic [1:0] far_kind,
   input  wire logic       far_pin,
   input  wire logic [1:0] far_cur,
   // comparator results
   output logic      [1:0] cc_level_code_raw,
   output logic            dac_compare_raw,
   output logic            vbus_valid_raw
);
   localparam logic [5:0] RD_LVL [4] = '{6'h10, 6'h10, 6'h20, 6'h30};
   localparam logic [5:0] RA_LVL [4] = '{6'h02, 6'h02, 6'h05, 6'h11};
   localparam logic [5:0] SRC_LVL [4] = '{6'h00, 6'h0a, 6'h20, 6'h36};
   logic       pin_sel;
   logic       pull_up;
   logic [5:0] lvl;
   assign pin_sel = !measure_cc1_select;
   assign pull_up = pin_sel ? cc2_pullup_enable : cc1_pullup_enable;
   assign vbus_valid_raw = far_kind == 2'd3;
   // unterminated pin floats up only while our pull-up sources current
   always_comb begin
      if (measure_vbus_select) lvl = vbus_valid_raw ? 6'h10 : 6'h00;
      else if (far_pin != pin_sel || far_kind == 2'd0) lvl = pull_up ? 6'h3f : 6'h00;
      else if (far_kind == 2'd3) lvl = pull_up ? 6'h3f : SRC_LVL[far_cur];
      else if (!pull_up) lvl = 6'h00;
      else lvl = far_kind == 2'd1 ? RD_LVL[source_current_select] : RA_LVL[source_current_select];
   end
   assign cc_level_code_raw = lvl < 6'h05 ? 2'd0 : lvl < 6'h10 ? 2'd1 : lvl < 6'h28 ? 2'd2 : 2'd3;
   assign dac_compare_raw = lvl >= dac_threshold_code;
endmodule : cc_far_port
`default_nettype wire

// ### typec_cc_attach_detection_monitor.sv
`timescale 1ns/1ns
`default_nettype none
`include "cc_detect_params.svh"
module typec_cc_attach_detection_monitor (
   // clock and register port
   input wire logic       core_clk,
   input wire logic       rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   // pin controls
   input wire logic       cc1_pulldown_enable,
   input wire logic       cc2_pulldown_enable,
   input wire logic       cc1_pullup_enable,
   input wire logic       cc2_pullup_enable,
   input wire logic       measure_cc1_select,
   input wire logic       measure_cc2_select,
   input wire logic       measure_vbus_select,
   input wire logic [5:0] dac_threshold_code,
   input wire logic [1:0] source_current_select,
   input wire logic       cable_power_to_cc1,
   input wire logic       cable_power_to_cc2,
   // interrupt
   input wire logic       int_n_out,
   input wire logic       int_n_oe
);
   logic       tog_q;
   logic [7:0] sw_q;
   logic [3:0] mask_q;
   logic [2:0] man_cnt;
   logic [2:0] tog_cnt;
   logic       cfg_wr;
   logic       cur_wr;
   logic       clr;
   logic [7:0] pins;
   assign cfg_wr = reg_wr && reg_addr <= `OFS_SWITCHES;
   assign cur_wr = reg_wr && reg_addr == `OFS_SRC_CURRENT;
   assign clr = (reg_rd || reg_wr) && reg_addr == `OFS_IRQ_STATUS
                || reg_wr && reg_addr == `OFS_IRQ_MASK;
   assign pins = {cable_power_to_cc2, cable_power_to_cc1, measure_cc2_select, measure_cc1_select,
                  cc2_pullup_enable, cc1_pullup_enable, cc2_pulldown_enable, cc1_pulldown_enable};
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         tog_q   <= 1'b0;
         sw_q    <= `RST_SWITCHES;
         mask_q  <= `RST_IRQ_MASK;
         man_cnt <= 3'd0;
         tog_cnt <= 3'd0;
      end else begin
         if (reg_wr && reg_addr == `OFS_CONTROL) tog_q <= reg_wdata[`CTL_TOGGLE_BIT];
         if (reg_wr && reg_addr == `OFS_SWITCHES) sw_q <= reg_wdata;
         if (reg_wr && reg_addr == `OFS_IRQ_MASK) mask_q <= reg_wdata[3:0];
         // pins lag a write by up to two edges, so count settle time
         man_cnt <= (cfg_wr || tog_q) ? 3'd0 : man_cnt + {2'd0, man_cnt != 3'd7};
         tog_cnt <= !tog_q ? 3'd0 : tog_cnt + {2'd0, tog_cnt != 3'd7};
      end
   end
   int_const_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      int_n_out == 1'b0) else $error("interrupt pin data not low");
   mask_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      mask_q == 4'hf && $past(mask_q) == 4'hf |-> !int_n_oe) else $error("masked irq pending");
   irq_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      int_n_oe && !clr && !$past(clr) |=> int_n_oe) else $error("irq dropped without clear");
   src_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      cur_wr |=> source_current_select == $past(reg_wdata[1:0])) else $error("current not taken");
   cur_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      !$past(cur_wr) |-> $stable(source_current_select)) else $error("current changed alone");
   meas_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      reg_rd && reg_addr == `OFS_MEASURE |=>
      reg_rdata == {1'b0, measure_vbus_select, dac_threshold_code}) else $error("bad dac read");
   manual_pins_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      man_cnt >= 3'd3 |-> pins == sw_q) else $error("pins differ from switches");
   toggle_pins_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      tog_cnt >= 3'd3 |-> (measure_cc1_select ^ measure_cc2_select)
      && !(cc1_pullup_enable && cc1_pulldown_enable)
      && !(cc2_pullup_enable && cc2_pulldown_enable)) else $error("bad toggle presentation");
endmodule : typec_cc_attach_detection_monitor
bind typec_cc_attach_detection typec_cc_attach_detection_monitor u_mon (
   .core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .cc1_pulldown_enable, .cc2_pulldown_enable, .cc1_pullup_enable, .cc2_pullup_enable,
   .measure_cc1_select, .measure_cc2_select, .measure_vbus_select, .dac_threshold_code,
   .source_current_select, .cable_power_to_cc1, .cable_power_to_cc2, .int_n_out, .int_n_oe);
`default_nettype wire

// ### test_typec_cc_attach_detection.sv
`timescale 1ns/1ns
`default_nettype none
`include "cc_detect_params.svh"
module test_typec_cc_attach_detection
   import cc_detect_pkg::*;
;
   localparam logic [1:0] MODE [3] = '{MODE_DUAL_ROLE, MODE_SOURCE_ONLY, MODE_SINK_ONLY};
   localparam logic [1:0] KIND [3] = '{2'd1, 2'd1, 2'd3};
   localparam logic       PIN [3]  = '{1'b1, 1'b0, 1'b0};
   localparam logic [2:0] RES [3]  = '{`TOG_SRC_CC2, `TOG_SRC_CC1, `TOG_SNK_CC1};
   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  reg_addr = 4'h0;
   reg_data_t   reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   reg_data_t   reg_rdata;
   reg_data_t   d;
   logic [1:0]  lvl_code;
   logic        cmp;
   logic        vbus;
   logic        pd1, pd2, pu1, pu2, m1, m2, mv, cab1, cab2, int_n_out, int_n_oe;
   logic [5:0]  dac;
   logic [1:0]  src_cur;
   logic [1:0]  far_kind = 2'd0;
   logic        far_pin = 1'b0;
   logic [1:0]  far_cur = 2'd1;
   logic [31:0] seed = 32'h38024879;
   int          errors = 0;
   int          compares = 0;
   always #10 core_clk = ~core_clk;
   typec_cc_attach_detection u_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .cc_level_code_raw(lvl_code), .dac_compare_raw(cmp), .vbus_valid_raw(vbus),
      .cc1_pulldown_enable(pd1), .cc2_pulldown_enable(pd2), .cc1_pullup_enable(pu1),
      .cc2_pullup_enable(pu2), .measure_cc1_select(m1), .measure_cc2_select(m2),
      .measure_vbus_select(mv), .dac_threshold_code(dac), .source_current_select(src_cur),
      .cable_power_to_cc1(cab1), .cable_power_to_cc2(cab2), .int_n_out(int_n_out),
      .int_n_oe(int_n_oe));
   cc_far_port u_far (.cc1_pullup_enable(pu1), .cc2_pullup_enable(pu2), .measure_cc1_select(m1),
      .measure_vbus_select(mv), .dac_threshold_code(dac), .source_current_select(src_cur),
      .far_kind(far_kind), .far_pin(far_pin), .far_cur(far_cur),
      .cc_level_code_raw(lvl_code), .dac_compare_raw(cmp), .vbus_valid_raw(vbus));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic reg_data_t ra_level(input int c);
      return 8'(c - 1);
   endfunction : ra_level
   function automatic reg_data_t rd_threshold(input int c);
      return c == 3 ? 8'h3e : 8'h26;
   endfunction : rd_threshold
   task automatic check(input reg_data_t seen, input reg_data_t exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input reg_data_t v);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      @(negedge core_clk);
      d = reg_rdata;
   endtask : rd
   // ends mid-cycle so outputs are settled when looked at
   task automatic pause(input int n);
      repeat (n) @(negedge core_clk);
   endtask : pause
   task automatic stop_test;
      if (errors == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : stop_test
   initial begin
      repeat (60000) @(posedge core_clk);
      errors++;
      stop_test();
   end
   initial begin
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int a = 0; a < 16; a++) begin
         if (a == `OFS_STATUS || a == `OFS_IRQ_STATUS) continue;
         rd(a[3:0]);
         check(d, a == 1 ? `RST_SWITCHES : a == 3 ? 8'h01 : 8'h00);
      end
      wr(4'hc, 8'hff);
      rd(4'hc);
      check(d, 8'h00);
      wr(`OFS_SWITCHES, 8'h14);
      for (int c = 1; c < 4; c++) begin
         wr(`OFS_SRC_CURRENT, c[7:0]);
         far_kind <= 2'd1;
         wr(`OFS_MEASURE, rd_threshold(c));
         pause(6);
         rd(`OFS_STATUS);
         check(d[2], 1'b0);
         @(posedge core_clk) far_kind <= 2'd2;
         wr(`OFS_MEASURE, c == 2 ? 8'h0a : 8'h13);
         pause(6);
         rd(`OFS_STATUS);
         check(d[1:0], ra_level(c));
         if (c > 1) check(d[2], 1'b0);
         @(posedge core_clk) far_kind <= 2'd0;
      end
      wr(`OFS_SRC_CURRENT, 8'h01);
      far_kind <= 2'd1;
      repeat (4) begin
         seed = lfsr(seed);
         wr(`OFS_MEASURE, {2'b00, seed[5:0]});
         pause(6);
         rd(`OFS_STATUS);
         check(d[2], seed[5:0] <= 6'h10);
      end
      rd(`OFS_IRQ_STATUS);
      @(posedge core_clk) far_kind <= 2'd0;
      pause(6);
      check(int_n_oe, 1'b1);
      rd(`OFS_IRQ_STATUS);
      check(d[1:0], 2'b11);
      pause(2);
      check(int_n_oe, 1'b0);
      rd(`OFS_IRQ_STATUS);
      check(d, 8'h00);
      wr(`OFS_IRQ_MASK, 8'h0f);
      far_kind <= 2'd1;
      pause(6);
      check(int_n_oe, 1'b0);
      rd(`OFS_IRQ_STATUS);
      check(d[1:0], 2'b11);
      repeat (3) begin
         seed = lfsr(seed);
         wr(`OFS_SRC_CURRENT, {6'h00, seed[1:0]});
         @(negedge core_clk);
         check(src_cur, seed[1:0]);
      end
      wr(`OFS_IRQ_MASK, 8'h0b);
      rd(`OFS_IRQ_STATUS);
      @(posedge core_clk) far_kind <= 2'd3;
      pause(6);
      check(int_n_oe, 1'b1);
      rd(`OFS_STATUS);
      check(d[3], 1'b1);
      rd(`OFS_IRQ_STATUS);
      check(d[2], 1'b1);
      @(posedge core_clk) far_kind <= 2'd0;
      pause(6);
      rd(`OFS_STATUS);
      check(d[3], 1'b0);
      check(int_n_oe, 1'b1);
      wr(`OFS_IRQ_STATUS, 8'h04);
      pause(1);
      check(int_n_oe, 1'b0);
      wr(`OFS_SWITCHES, 8'h13);
      far_kind <= 2'd3;
      for (int c = 1; c < 4; c++) begin
         @(posedge core_clk) far_cur <= c[1:0];
         pause(6);
         rd(`OFS_STATUS);
         check(d[1:0], c[7:0]);
      end
      wr(`OFS_MEASURE, 8'h48);
      pause(6);
      rd(`OFS_STATUS);
      check(d[2], 1'b1);
      wr(`OFS_MEASURE, 8'h51);
      pause(6);
      rd(`OFS_STATUS);
      check(d[2], 1'b0);
      for (int t = 0; t < 3; t++) begin
         wr(`OFS_CONTROL, 8'h00);
         wr(`OFS_SRC_CURRENT, 8'h01);
         wr(`OFS_SWITCHES, 8'h00);
         wr(`OFS_MEASURE, 8'h26);
         far_kind <= KIND[t];
         far_pin  <= PIN[t];
         wr(`OFS_IRQ_MASK, 8'h07);
         pause(6);
         rd(`OFS_IRQ_STATUS);
         wr(`OFS_CONTROL, {5'd0, MODE[t], 1'b1});
         for (int w = 0; w < 10000 && int_n_oe !== 1'b1; w++) @(negedge core_clk);
         rd(`OFS_STATUS);
         check(d[6:4], RES[t]);
         rd(`OFS_IRQ_STATUS);
         check(d[3], 1'b1);
      end
      wr(`OFS_CONTROL, 8'h00);
      wr(`OFS_SWITCHES, 8'he8);
      pause(4);
      check({cab2, cab1, m2, m1, pu2, pu1, pd2, pd1}, 8'he8);
      stop_test();
   end
endmodule : test_typec_cc_attach_detection
`default_nettype wire
